// >>> ceb_entry_builder.sv
`timescale 1ns/1ps
`default_nettype none
module ceb_entry_builder
  import ceb_pkg::*;
#(
  parameter int QUEUE_DEPTH = 16,
  parameter int IDX_W = $clog2(QUEUE_DEPTH)
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Configuration pins
  input wire logic controller_enable_bit,
  input wire logic network_variant,
  // Completion request
  input wire logic cpl_valid,
  output logic cpl_ready,
  input wire logic dw0_used,
  input wire logic [31:0] cmd_dword0,
  input wire logic [15:0] issue_queue_id,
  input wire logic [15:0] issue_queue_head,
  input wire logic cpl_success,
  input wire logic [14:0] completion_status_word,
  input wire logic [15:0] host_command_tag,
  // Memory write stream, one dword a beat
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [IDX_W-1:0] wr_slot,
  output logic [1:0] wr_dword,
  output logic [31:0] wr_data,
  output logic wr_last,
  // Status
  output logic [IDX_W-1:0] tail_index,
  output logic phase_tag
);

  //////////////////////////////////////////////////////////////////////////
  // Enable pin synchroniser
  logic enable_s;
  ceb_sync u_en_sync (
    .core_clk(core_clk),
    .reset(reset),
    .din(controller_enable_bit),
    .dout(enable_s)
  );

  //////////////////////////////////////////////////////////////////////////
  // State
  ceb_state_type state_q, state_d;
  logic [31:0] ent_q [CEB_DWORDS];
  logic [1:0] dw_q;
  logic [IDX_W-1:0] tail_q;
  logic phase_q;
  logic [31:0] data_q;

  wire take = (state_q == CEB_IDLE) && cpl_valid && enable_s;
  wire beat = wr_valid && wr_ready;
  wire beat_last = beat && (dw_q == CEB_DW_LAST);
  wire tail_wrap = tail_q == IDX_W'(QUEUE_DEPTH - 1);

  // Success forces a zero status word
  wire [14:0] status_w = cpl_success ? CEB_STATUS_OK
                                     : completion_status_word;
  wire [31:0] dw0_w = dw0_used ? cmd_dword0 : CEB_RSVD_DWORD;
  wire [15:0] issue_queue_id_w = network_variant ? 16'h0000
                                       : issue_queue_id;
  wire [31:0] dw2_w = {issue_queue_id_w, issue_queue_head};
  wire phase_w = network_variant ? 1'b0 : phase_q;
  // Status word keeps category at 27:25 and detail at 24:17
  wire [31:0] dw3_w = {status_w, phase_w, host_command_tag};

  assign cpl_ready = (state_q == CEB_IDLE) && enable_s;
  assign wr_valid = (state_q == CEB_SEND) || (state_q == CEB_LAST);
  assign wr_last = state_q == CEB_LAST;
  assign wr_dword = dw_q;
  assign wr_slot = tail_q;
  assign wr_data = data_q;
  assign tail_index = tail_q;
  assign phase_tag = phase_q;

  // Dword order 0,1,2,3 so dword three with the phase goes last
  wire [1:0] dw_next = dw_q + 2'h1;

  always_comb begin
    state_d = state_q;
    case (state_q)
      CEB_IDLE: begin
        if (take) begin
          state_d = CEB_SEND;
        end
      end
      CEB_SEND: begin
        if (beat && dw_next == CEB_DW_LAST) begin
          state_d = CEB_LAST;
        end
      end
      CEB_LAST: begin
        if (beat) begin
          state_d = CEB_IDLE;
        end
      end
      default: state_d = CEB_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Entry capture; head is frozen here, later advances are not seen
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < CEB_DWORDS; i++) begin
        ent_q[i] <= CEB_RSVD_DWORD;
      end
    end else if (take) begin
      ent_q[0] <= dw0_w;
      ent_q[1] <= CEB_RSVD_DWORD;
      ent_q[2] <= dw2_w;
      ent_q[3] <= dw3_w;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q <= CEB_IDLE;
      dw_q <= 2'h0;
      data_q <= CEB_RSVD_DWORD;
    end else begin
      state_q <= state_d;
      if (take) begin
        dw_q <= 2'h0;
        data_q <= dw0_w;
      end else if (beat) begin
        dw_q <= dw_next;
        data_q <= ent_q[dw_next];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Tail and phase; disable rearms phase to one for the next first pass
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tail_q <= '0;
      phase_q <= CEB_PHASE_INIT;
    end else if (!enable_s) begin
      tail_q <= '0;
      phase_q <= CEB_PHASE_INIT;
    end else if (beat_last) begin
      if (tail_wrap) begin
        tail_q <= '0;
        phase_q <= ~phase_q;
      end else begin
        tail_q <= tail_q + IDX_W'(1);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_entry_taken;
    take ##1 wr_valid && wr_dword == 2'h0;
  endsequence

  property p_start;
    @(posedge core_clk) disable iff (reset)
      take |-> ##1 (wr_valid && wr_dword == 2'h0 && !wr_last);
  endproperty
  a_start: assert property (p_start) else $error("entry did not start");

  property p_dw1_rsvd;
    @(posedge core_clk) disable iff (reset)
      (wr_valid && wr_dword == 2'h1) |-> wr_data == 32'h0000_0000;
  endproperty
  a_dw1_rsvd: assert property (p_dw1_rsvd) else $error("dword1 nonzero");

  property p_last_is_dw3;
    @(posedge core_clk) disable iff (reset)
      wr_valid |-> (wr_last == (wr_dword == 2'h3));
  endproperty
  a_last_is_dw3: assert property (p_last_is_dw3) else $error("bad last");

  property p_dw0;
    @(posedge core_clk) disable iff (reset)
      take && !dw0_used |-> ##1 wr_data == 32'h0000_0000;
  endproperty
  a_dw0: assert property (p_dw0) else $error("dword0 not reserved");

  property p_head;
    @(posedge core_clk) disable iff (reset)
      s_entry_taken ##0 (wr_ready [*2]) |=>
        wr_data[15:0] == $past(issue_queue_head, 3);
  endproperty
  a_head: assert property (p_head) else $error("head not sampled");

  property p_wrap;
    @(posedge core_clk) disable iff (reset)
      beat_last && tail_wrap && enable_s |=>
        tail_q == '0 && phase_q != $past(phase_q);
  endproperty
  a_wrap: assert property (p_wrap) else $error("phase not inverted");

  property p_no_wrap;
    @(posedge core_clk) disable iff (reset)
      beat_last && !tail_wrap && enable_s |=> $stable(phase_q);
  endproperty
  a_no_wrap: assert property (p_no_wrap) else $error("phase moved");

  property p_first_pass;
    @(posedge core_clk) disable iff (reset)
      !enable_s |=> phase_q && tail_q == '0;
  endproperty
  a_first_pass: assert property (p_first_pass) else $error("no rearm");

  property p_phase_out;
    @(posedge core_clk) disable iff (reset)
      wr_valid && wr_last && enable_s |->
        wr_data[CEB_PHASE_BIT] == (phase_q & ~network_variant);
  endproperty
  a_phase_out: assert property (p_phase_out) else $error("bad phase");

  property p_fabric;
    @(posedge core_clk) disable iff (reset)
      take && network_variant |-> ##1 ent_q[3][16] == 1'b0
        && ent_q[2][31:16] == 16'h0000;
  endproperty
  a_fabric: assert property (p_fabric) else $error("fields not reserved");

  property p_hold;
    @(posedge core_clk) disable iff (reset)
      wr_valid && !wr_ready |=>
        wr_valid && $stable(wr_data) && $stable(wr_dword);
  endproperty
  a_hold: assert property (p_hold) else $error("beat dropped");

  // Tail moves one slot per finished entry
  property p_advance;
    @(posedge core_clk) disable iff (reset)
      beat_last && !tail_wrap && enable_s |=>
        tail_q == $past(tail_q) + IDX_W'(1);
  endproperty
  a_advance: assert property (p_advance) else $error("tail skipped");

  property p_end;
    @(posedge core_clk) disable iff (reset)
      wr_valid && wr_last && wr_ready |=> !wr_valid;
  endproperty
  a_end: assert property (p_end) else $error("entry overran");

  property p_issue_queue_id;
    @(posedge core_clk) disable iff (reset)
      take && !network_variant |=>
        ent_q[2][31:16] == $past(issue_queue_id);
  endproperty
  a_issue_queue_id: assert property (p_issue_queue_id) else $error("queue id lost");

  property p_tag;
    @(posedge core_clk) disable iff (reset)
      take |=> ent_q[3][15:0] == $past(host_command_tag);
  endproperty
  a_tag: assert property (p_tag) else $error("command tag lost");

  property p_status;
    @(posedge core_clk) disable iff (reset)
      take && !cpl_success |=>
        ent_q[3][31:17] == $past(completion_status_word);
  endproperty
  a_status: assert property (p_status) else $error("status lost");

  // Category and detail checked apart so a swapped field shows up
  property p_fields;
    @(posedge core_clk) disable iff (reset)
      take && !cpl_success |=>
        ent_q[3][27:25] == $past(completion_status_word[10:8])
        && ent_q[3][24:17] == $past(completion_status_word[7:0]);
  endproperty
  a_fields: assert property (p_fields) else $error("status split");

  property p_success;
    @(posedge core_clk) disable iff (reset)
      take && cpl_success |=> ent_q[3][31:17] == 15'h0000;
  endproperty
  a_success: assert property (p_success) else $error("bad success");

  property p_dw0_used;
    @(posedge core_clk) disable iff (reset)
      take && dw0_used |=> wr_data == $past(cmd_dword0);
  endproperty
  a_dw0_used: assert property (p_dw0_used) else $error("dword0 lost");

endmodule : ceb_entry_builder
`default_nettype wire

// >>> ceb_pkg.sv
package ceb_pkg;
  // Entry layout
  localparam int CEB_ENTRY_BYTES = 16;
  localparam int CEB_DWORDS = 4;
  localparam int CEB_ISSUE_QUEUE_ID_LSB = 16;
  localparam int CEB_PHASE_BIT = 16;
  localparam int CEB_STATUS_LSB = 17;
  localparam int CEB_SCT_LSB = 8;
  localparam int CEB_SC_LSB = 0;
  // Reset and initial values
  localparam logic CEB_PHASE_INIT = 1'b1;
  localparam logic [31:0] CEB_RSVD_DWORD = 32'h0000_0000;
  localparam logic [14:0] CEB_STATUS_OK = 15'h0000;
  localparam logic [1:0] CEB_DW_LAST = 2'h3;
  localparam int CEB_SYNC_STAGES = 3;
  typedef enum logic [1:0] {
    CEB_IDLE = 2'b00,
    CEB_SEND = 2'b01,
    CEB_LAST = 2'b11
  } ceb_state_type;
endpackage : ceb_pkg

// >>> ceb_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ceb_sync
  import ceb_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Level in and out
  input wire logic din,
  output logic dout
);
  logic [CEB_SYNC_STAGES-1:0] stage_q;
  logic dout_q;
  // Change accepted only when stages two and three agree
  wire agree = stage_q[1] == stage_q[2];
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      stage_q <= '0;
      dout_q <= 1'b0;
    end else begin
      stage_q <= {stage_q[1:0], din};
      if (agree) begin
        dout_q <= stage_q[2];
      end
    end
  end
  assign dout = dout_q;
endmodule : ceb_sync
`default_nettype wire

// >>> ceb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ceb_host_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Queue memory write stream
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [3:0] wr_slot,
  input wire logic [1:0] wr_dword,
  input wire logic [31:0] wr_data,
  input wire logic wr_last,
  // Slow sink when high
  input wire logic stall
);
  logic [31:0] mem [16][4];
  logic [1:0] next_dw = 2'h0;
  int entries = 0;
  int order_bad = 0;
  initial wr_ready = 1'b0;
  // Every slot holds phase zero before enable
  initial foreach (mem[s, d]) mem[s][d] = 32'h0000_0000;
  ////////////////////////////////////////////////////////////////////////
  // Stalling alternates ready so beats must hold across waits
  always @(posedge core_clk) begin
    wr_ready <= stall ? ~wr_ready : 1'b1;
    if (reset) begin
      next_dw <= 2'h0;
    end else if (wr_valid && wr_ready) begin
      mem[wr_slot][wr_dword] <= wr_data;
      if (wr_dword !== next_dw || wr_last !== (wr_dword == 2'h3)) begin
        order_bad++;
      end
      next_dw <= wr_dword + 2'h1;
      if (wr_last) begin
        entries++;
      end
    end
  end
endmodule : ceb_host_model
`default_nettype wire

// >>> tb_completion_entry_builder.sv
`timescale 1ns/1ps
`default_nettype none
module tb_completion_entry_builder;
  import ceb_pkg::*;
  typedef struct packed {
    logic used;
    logic [31:0] dw0;
    logic [15:0] id;
    logic [15:0] head;
    logic ok;
    logic [14:0] st;
    logic [15:0] tag;
    logic net;
  } ceb_row_type;
  logic core_clk = 0, reset = 1, en = 0, net = 0, cpl_valid = 0;
  logic dw0_used = 0, ok = 0, stall = 0;
  logic [31:0] cmd = 0;
  logic [15:0] qid = 0, qhead = 0, tag = 0;
  logic [14:0] st = 0;
  logic cpl_ready, wr_valid, wr_ready, wr_last, phase;
  logic [3:0] wr_slot, tail;
  logic [1:0] wr_dword;
  logic [31:0] wr_data;
  int fails = 0;
  int n_compared = 0;
  ceb_row_type rows [4] = '{
    '{1, 32'hCAFE_0001, 16'h0003, 16'h0011, 0, 15'h0281, 16'hA001, 0},
    '{0, 32'hFFFF_FFFF, 16'hFFFF, 16'hFFFF, 1, 15'h7FFF, 16'h0000, 0},
    '{1, 32'h1234_5678, 16'h00AB, 16'h0000, 0, 15'h7FFF, 16'hFFFF, 1},
    '{0, 32'h0000_0000, 16'h8000, 16'h00FE, 1, 15'h0000, 16'h5A5A, 1}};
  ceb_entry_builder #(.QUEUE_DEPTH(16)) i_ceb_entry_builder (
    .core_clk(core_clk), .reset(reset), .controller_enable_bit(en),
    .network_variant(net), .cpl_valid(cpl_valid), .cpl_ready(cpl_ready),
    .dw0_used(dw0_used), .cmd_dword0(cmd), .issue_queue_id(qid),
    .issue_queue_head(qhead), .cpl_success(ok),
    .completion_status_word(st), .host_command_tag(tag),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_slot(wr_slot),
    .wr_dword(wr_dword), .wr_data(wr_data), .wr_last(wr_last),
    .tail_index(tail), .phase_tag(phase));
  ceb_host_model i_ceb_host_model (
    .core_clk(core_clk), .reset(reset), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_slot(wr_slot), .wr_dword(wr_dword),
    .wr_data(wr_data), .wr_last(wr_last), .stall(stall));
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [31:0] exp_dw(ceb_row_type r, int d, logic ph);
    case (d)
      0: return r.used ? r.dw0 : CEB_RSVD_DWORD;
      1: return CEB_RSVD_DWORD;
      2: return {r.net ? 16'h0000 : r.id, r.head};
      default: return {r.ok ? CEB_STATUS_OK : r.st, ph & ~r.net, r.tag};
    endcase
  endfunction : exp_dw
  // One entry in flight keeps queue and tag pairs unique
  task automatic post(input ceb_row_type r);
    int n;
    n = i_ceb_host_model.entries;
    @(posedge core_clk);
    {dw0_used, cmd, qid, qhead, ok, st, tag, net} <= r;
    cpl_valid <= 1'b1;
    @(negedge core_clk);
    while (cpl_ready !== 1'b1) @(negedge core_clk);
    @(posedge core_clk);
    cpl_valid <= 1'b0;
    qhead <= ~r.head;
    while (i_ceb_host_model.entries == n) @(negedge core_clk);
  endtask : post
  task automatic check_entry(input ceb_row_type r, int s, logic ph);
    for (int d = 0; d < CEB_DWORDS; d++) begin
      chk(i_ceb_host_model.mem[s][d], exp_dw(r, d, ph));
    end
  endtask : check_entry
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    en <= 1'b1;
    for (int i = 0; i < 17; i++) begin
      post(rows[i % 4]);
      check_entry(rows[i % 4], i % 16, i < 16);
    end
    chk({27'h0, tail, phase}, 32'h2);
    chk(32'(i_ceb_host_model.order_bad), 32'h0);
    @(posedge core_clk);
    stall <= 1'b1;
    en <= 1'b0;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    chk({27'h0, tail, phase}, 32'h1);
    @(posedge core_clk);
    en <= 1'b1;
    post(rows[0]);
    check_entry(rows[0], 0, 1'b1);
    chk(32'(i_ceb_host_model.order_bad), 32'h0);
    @(posedge core_clk);
    reset <= 1'b1;
    @(negedge core_clk);
    chk({24'h0, cpl_ready, wr_valid, wr_last, tail, phase}, 32'h1);
    chk(wr_data, 32'h0);
    @(posedge core_clk);
    reset <= 1'b0;
    post(rows[1]);
    check_entry(rows[1], 0, 1'b1);
    chk(32'(i_ceb_host_model.order_bad), 32'h0);
    print_verdict();
  end
  // Some 19 entries of about six cycles each, two with stall
  initial begin
    repeat (3000) @(posedge core_clk);
    fails++;
    print_verdict();
  end
endmodule : tb_completion_entry_builder
`default_nettype wire
